// [nvp_checker.sv]
/* Port checker for nvp_ctrl: bus handshake and line state rules.
 * Assumes the bind below and the default line parameters of the top module. */
`timescale 1ns/1ns
`include "nvp_regs.svh"
module nvp_checker
  import nvp_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst,
  input wire nvp_pkg::nvp_addr_t avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire nvp_pkg::nvp_word_t avs_writedata,
  input wire nvp_pkg::nvp_be_t   avs_byteenable,
  input wire logic               avs_waitrequest,
  input wire logic [31:0]        irq_lines,
  input wire logic               exception_entry_event,
  input wire nvp_pkg::nvp_idx_t  entry_line_index,
  input wire logic               exception_return_event,
  input wire nvp_pkg::nvp_idx_t  return_line_index,
  input wire logic [31:0]        line_pending_bits,
  input wire logic [31:0]        line_enabled_bits,
  input wire logic [31:0]        line_active_bits
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic wr_all;
  // Full-word write completing at this edge
  assign wr_all = avs_write && !avs_waitrequest && (avs_byteenable == 4'hF);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus answers after exactly one wait cycle
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop after one cycle");
  chk_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_en_set: assert property (wr_all && avs_address == `NVP_OFS_EN_SET |=>
    (line_enabled_bits & $past(avs_writedata)) == $past(avs_writedata)) else $error("enable set lost");
  chk_en_clr: assert property (wr_all && avs_address == `NVP_OFS_EN_CLR |=>
    (line_enabled_bits & $past(avs_writedata)) == '0) else $error("enable clear lost");
  chk_entry_act: assert property (exception_entry_event && line_enabled_bits[entry_line_index] |=>
    line_active_bits[$past(entry_line_index)]) else $error("entry did not activate line");
  chk_masked_idle: assert property (exception_entry_event && !line_enabled_bits[entry_line_index] &&
    !line_active_bits[entry_line_index] |=> !line_active_bits[$past(entry_line_index)])
    else $error("disabled line activated");
  chk_ret_clear: assert property (exception_return_event && !exception_entry_event |=>
    !line_active_bits[$past(return_line_index)]) else $error("return left line active");
  chk_act_hold: assert property (!exception_return_event && !avs_write |=>
    (line_active_bits & $past(line_active_bits)) == $past(line_active_bits)) else $error("active dropped");
  chk_pend_hold: assert property (!exception_entry_event && !avs_write |=>
    (line_pending_bits & $past(line_pending_bits)) == $past(line_pending_bits)) else $error("pending dropped");
  // Input rise reaches pending within the two-stage sync delay
  for (genvar g = 0; g < 32; g++) begin : g_rise
    chk_pend_rise: assert property ($rose(irq_lines[g]) ##1 irq_lines[g] |-> ##[1:3]
      (line_pending_bits[g] || line_active_bits[g])) else $error("input rise not pended");
  end
  // Main scenarios reached
  cov_entry: cover property (exception_entry_event && line_enabled_bits[entry_line_index]);
  cov_ret_hi: cover property (exception_return_event && irq_lines[return_line_index]);
  cov_clr_all: cover property (wr_all && avs_address == `NVP_OFS_APP_CTRL);
endmodule : nvp_checker

bind nvp_ctrl nvp_checker i_chk (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_waitrequest, .irq_lines, .exception_entry_event, .entry_line_index,
  .exception_return_event, .return_line_index, .line_pending_bits, .line_enabled_bits, .line_active_bits);

// [nvp_ctrl.sv]
/*
 * Pending, enable and priority logic for 32 external interrupt lines,
 * with an Avalon-MM register slave and a summary interrupt output.
 * Assumes peripheral lines are asynchronous pins and that the exception
 * entry and return strobes come from logic on clk.
 */
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
`include "nvp_regs.svh"

// Notes on behaviour
// - Up to 32 lines, each with enable, pending, priority and index.
// - Both level and pulse sources are handled.
// - A pulse during the active period sets pending once.
// - A level still high at exception return sets pending again.
// - Enable set/clear registers are write-one; both read the enables.
// - Disabled lines still go pending but never activate.
// - Disabling an active line leaves it active until return, clear-all-active or reset.
// - Enables may be tied to zero or one per line.
// - Pending set/clear registers are write-one; both read the pending bits.
// - Clearing pending never changes the active state.
// - Software set and clear of pending is chosen per line.
// - Each line has an 8-bit priority, four per 32-bit word.
// - Inputs are active high unless LINE_LOW is set; type and sense chosen per line.
// - Assertion is a rising edge, or high at clear-all-active or return.
// - Pending clears on entry while enabled, or clear write while input is low.
// - Pending sets on assertion or set write, else holds.
module nvp_ctrl
  import nvp_pkg::*;
#(
  parameter logic [31:0] LINE_PRESENT = 32'hFFFF_FFFF,
  parameter logic [31:0] LINE_FIXED   = 32'h0000_0000,
  parameter logic [31:0] LINE_PULSE   = 32'hFFFF_FFFF,
  parameter logic [31:0] LINE_LOW     = 32'h0000_0000,
  parameter logic [31:0] LINE_SW_SET  = 32'hFFFF_FFFF,
  parameter logic [31:0] LINE_SW_CLR  = 32'hFFFF_FFFF
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire nvp_pkg::nvp_addr_t avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire nvp_pkg::nvp_word_t avs_writedata,
  input  wire nvp_pkg::nvp_be_t   avs_byteenable,
  output nvp_pkg::nvp_word_t avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic [31:0]   irq_lines,
  input  wire logic          exception_entry_event,
  input  wire nvp_pkg::nvp_idx_t entry_line_index,
  input  wire logic          exception_return_event,
  input  wire nvp_pkg::nvp_idx_t return_line_index,
  output logic [31:0]        line_pending_bits,
  output logic [31:0]        line_enabled_bits,
  output logic [31:0]        line_active_bits,
  output logic [31:0]        line_request_bits,
  output logic [255:0]       line_priority_bits,
  output logic               ctrl_irq
);
  import nvp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0]  irq_meta_ff;
  logic [31:0]  irq_sync_ff;
  logic [31:0]  irq_prev_ff;
  logic [31:0]  irq_level;
  logic [31:0]  irq_rise;
  logic         wait_ff;
  nvp_word_t    rdata_ff;
  nvp_word_t    nxt_rdata;
  logic         acc;
  logic         wr_acc;
  nvp_word_t    wmask;
  nvp_word_t    wbits;
  logic         wr_en_set;
  logic         wr_en_clr;
  logic         wr_pend_set;
  logic         wr_pend_clr;
  logic         wr_app;
  logic         wr_ev_clr;
  logic         wr_ev_en;
  logic         wr_prio;
  logic [2:0]   prio_idx;
  logic         clr_all;
  nvp_word_t    prio_ff [0:7];
  logic [31:0]  entry_dec;
  logic [31:0]  ret_dec;
  logic [31:0]  pend_w;
  logic [31:0]  en_w;
  logic [31:0]  act_w;
  logic [31:0]  ev_pend_w;
  logic [31:0]  ev_repend_w;
  logic [31:0]  ev_masked_w;
  logic [31:0]  req_ff;
  logic [`NVP_EV_BITS-1:0] ev_stat_ff;
  logic [`NVP_EV_BITS-1:0] ev_en_ff;
  logic [`NVP_EV_BITS-1:0] ev_new;
  logic         irq_ff;

  ////////////////////////////////////////////////////////////////////////
  // Input synchroniser; the first stage feeds only the second
  // one clock period is enough to be caught
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_meta_ff <= LINE_LOW;
      irq_sync_ff <= LINE_LOW;
      irq_prev_ff <= LINE_LOW;
    end else begin
      irq_meta_ff <= irq_lines;
      irq_sync_ff <= irq_meta_ff;
      irq_prev_ff <= irq_sync_ff;
    end
  end

  // Sense correction after the synchroniser
  // lines seen active high inside
  assign irq_level = irq_sync_ff ^ LINE_LOW;
  // low to high on a clock edge
  assign irq_rise  = irq_level & ~(irq_prev_ff ^ LINE_LOW);

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave timing: one wait cycle, then the access completes.
  // Waitrequest idles high so it can come straight from a flop.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !((avs_read | avs_write) & wait_ff);
    end
  end

  assign acc    = (avs_read | avs_write) & !wait_ff;
  assign wr_acc = avs_write & !wait_ff;

  // Byte lanes expanded to a bit mask
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wbits = avs_writedata & wmask;

  ////////////////////////////////////////////////////////////////////////
  // Write decode
  always_comb begin
    wr_en_set   = 1'b0;
    wr_en_clr   = 1'b0;
    wr_pend_set = 1'b0;
    wr_pend_clr = 1'b0;
    wr_app      = 1'b0;
    wr_ev_clr   = 1'b0;
    wr_ev_en    = 1'b0;
    wr_prio     = 1'b0;
    if (!wr_acc) begin
      wr_prio = 1'b0;
    end else if (avs_address == `NVP_OFS_EN_SET) begin
      wr_en_set = 1'b1;
    end else if (avs_address == `NVP_OFS_EN_CLR) begin
      wr_en_clr = 1'b1;
    end else if (avs_address == `NVP_OFS_PEND_SET) begin
      wr_pend_set = 1'b1;
    end else if (avs_address == `NVP_OFS_PEND_CLR) begin
      wr_pend_clr = 1'b1;
    end else if (avs_address == `NVP_OFS_APP_CTRL) begin
      wr_app = 1'b1;
    end else if (avs_address == `NVP_OFS_EV_CLR) begin
      wr_ev_clr = 1'b1;
    end else if (avs_address == `NVP_OFS_EV_EN) begin
      wr_ev_en = 1'b1;
    end else if (avs_address >= `NVP_OFS_PRIO0 && avs_address <= `NVP_OFS_PRIO7 &&
                 avs_address[1:0] == 2'b00) begin
      wr_prio = 1'b1;
    end
  end

  assign prio_idx = avs_address[4:2];
  // Clear-all-active write; a one-cycle pulse
  assign clr_all  = wr_app & wbits[`NVP_CLRACT_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Priority words, byte lanes honoured
  // 8-bit fields, four per word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `NVP_PRIO_REGS; i++) begin
        prio_ff[i] <= `NVP_RST_WORD;
      end
    end else if (wr_prio) begin
      prio_ff[prio_idx] <= (prio_ff[prio_idx] & ~wmask) | wbits;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Exception entry and return decoded to one strobe per line
  // index selects one of 32 lines
  always_comb begin
    entry_dec = '0;
    ret_dec   = '0;
    if (exception_entry_event) begin
      entry_dec[entry_line_index] = 1'b1;
    end
    if (exception_return_event) begin
      ret_dec[return_line_index] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One line block per interrupt
  // software set and clear chosen per line
  genvar g;
  generate
    for (g = 0; g < `NVP_LINES; g++) begin : gen_line
      nvp_line #(
        .PRESENT   (LINE_PRESENT[g]),
        .ALWAYS_EN (LINE_FIXED[g]),
        .PULSE     (LINE_PULSE[g]),
        .SW_SET    (LINE_SW_SET[g]),
        .SW_CLR    (LINE_SW_CLR[g])
      ) u_line (
        .clk       (clk),
        .rst       (rst),
        .irq_level (irq_level[g]),
        .irq_rise  (irq_rise[g]),
        .sample_hi (clr_all | ret_dec[g]),
        .entry     (entry_dec[g]),
        .ret       (ret_dec[g]),
        .clr_all   (clr_all),
        .set_en    (wr_en_set & wbits[g]),
        .clr_en    (wr_en_clr & wbits[g]),
        // write one sets or clears pending
        .set_pend  (wr_pend_set & wbits[g]),
        .clr_pend  (wr_pend_clr & wbits[g]),
        .pending   (pend_w[g]),
        .enabled   (en_w[g]),
        .active    (act_w[g]),
        .ev_pend   (ev_pend_w[g]),
        .ev_repend (ev_repend_w[g]),
        .ev_masked (ev_masked_w[g])
      );
      // Priority fields flattened for the exception logic
      assign line_priority_bits[g*`NVP_PRIO_W +: `NVP_PRIO_W] =
        prio_ff[g/4][(g%4)*`NVP_PRIO_W +: `NVP_PRIO_W];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read mux, loaded during the wait cycle so data stands at completion
  always_comb begin
    nxt_rdata = `NVP_RST_WORD;
    if (avs_address == `NVP_OFS_EN_SET || avs_address == `NVP_OFS_EN_CLR) begin
      nxt_rdata = en_w;
    end else if (avs_address == `NVP_OFS_PEND_SET || avs_address == `NVP_OFS_PEND_CLR) begin
      nxt_rdata = pend_w;
    end else if (avs_address >= `NVP_OFS_PRIO0 && avs_address <= `NVP_OFS_PRIO7 &&
                 avs_address[1:0] == 2'b00) begin
      nxt_rdata = prio_ff[prio_idx];
    end else if (avs_address == `NVP_OFS_ACTIVE) begin
      nxt_rdata = act_w;
    end else if (avs_address == `NVP_OFS_EV_STAT) begin
      nxt_rdata = {29'h0, ev_stat_ff};
    end else if (avs_address == `NVP_OFS_EV_EN) begin
      nxt_rdata = {29'h0, ev_en_ff};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= `NVP_RST_WORD;
    end else if (avs_read & wait_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event status: sticky, set beats a same-cycle clear
  assign ev_new[`NVP_EV_PEND]   = |ev_pend_w;
  assign ev_new[`NVP_EV_REPEND] = |ev_repend_w;
  assign ev_new[`NVP_EV_MASKED] = |ev_masked_w;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_stat_ff <= `NVP_RST_EV;
    end else if (wr_ev_clr) begin
      ev_stat_ff <= ev_new | (ev_stat_ff & ~wbits[`NVP_EV_BITS-1:0]);
    end else begin
      ev_stat_ff <= ev_new | ev_stat_ff;
    end
  end

  // Event enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_en_ff <= `NVP_RST_EV;
    end else if (wr_ev_en) begin
      ev_en_ff <= wbits[`NVP_EV_BITS-1:0];
    end
  end

  // Summary interrupt, one cycle behind the status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(ev_stat_ff & ev_en_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lines ready for the exception logic: pending, enabled, not active.
  // Ranking by priority is left to the exception logic.
  // disabled lines never request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_ff <= `NVP_RST_WORD;
    end else begin
      req_ff <= pend_w & en_w & ~act_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_readdata      = rdata_ff;
  assign avs_waitrequest   = wait_ff;
  assign line_pending_bits = pend_w;
  assign line_enabled_bits = en_w;
  assign line_active_bits  = act_w;
  assign line_request_bits = req_ff;
  assign ctrl_irq          = irq_ff;
endmodule : nvp_ctrl

// [nvp_ctrl_tb_top.sv]
/* Testbench for nvp_ctrl: register access, line events and the summary interrupt.
 * Assumes nvp_src_model plays the sources and exception logic; line 5 is level type. */
`timescale 1ns/1ns
`include "nvp_regs.svh"
module nvp_ctrl_tb_top;
  import nvp_pkg::*;
  logic         clk;
  logic         rst;
  nvp_addr_t    avs_address;
  logic         avs_read;
  logic         avs_write;
  nvp_word_t    avs_writedata;
  nvp_be_t      avs_byteenable;
  nvp_word_t    avs_readdata;
  logic         avs_waitrequest;
  logic [31:0]  irq_lines;
  logic         exception_entry_event;
  nvp_idx_t     entry_line_index;
  logic         exception_return_event;
  nvp_idx_t     return_line_index;
  logic [31:0]  line_pending_bits;
  logic [31:0]  line_enabled_bits;
  logic [31:0]  line_active_bits;
  logic [31:0]  line_request_bits;
  logic [255:0] line_priority_bits;
  logic         ctrl_irq;
  int           num_errors;
  int           checks_done;
  int           cycles;

  nvp_ctrl #(.LINE_PULSE(32'hFFFF_FFDF)) i_dut (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq_lines,
    .exception_entry_event, .entry_line_index,
    .exception_return_event, .return_line_index, .line_pending_bits, .line_enabled_bits,
    .line_active_bits, .line_request_bits, .line_priority_bits, .ctrl_irq);
  nvp_src_model i_src (.clk, .irq_lines, .exception_entry_event, .entry_line_index,
    .exception_return_event, .return_line_index);

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input nvp_word_t got, input nvp_word_t exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // One bus access; held until waitrequest is seen low, data taken in that cycle
  task automatic bus(input logic w, input nvp_addr_t a, input nvp_word_t d, input nvp_be_t be,
                     output nvp_word_t q);
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input nvp_addr_t a, input nvp_word_t d, input nvp_be_t be = 4'hF);
    nvp_word_t q;
    bus(1'b1, a, d, be, q);
  endtask : wr
  task automatic rd(input nvp_addr_t a, input nvp_word_t exp);
    nvp_word_t q;
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
    cmp(q, exp);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////////
  // Reset state, then enable and pending set and clear registers, then a hole in the map
  task automatic t_regs();
    rd(`NVP_OFS_ACTIVE, 32'h0000_0000);
    rd(`NVP_OFS_PEND_SET, 32'h0000_0000);
    wr(`NVP_OFS_EN_SET, 32'hA5A5_0F0F);
    rd(`NVP_OFS_EN_CLR, 32'hA5A5_0F0F);
    wr(`NVP_OFS_EN_CLR, 32'h0000_0F00);
    rd(`NVP_OFS_EN_SET, 32'hA5A5_000F);
    wr(`NVP_OFS_EN_CLR, 32'hFFFF_FFFF);
    rd(`NVP_OFS_EN_SET, 32'h0000_0000);
    wr(`NVP_OFS_PEND_SET, 32'h8000_0001);
    rd(`NVP_OFS_PEND_CLR, 32'h8000_0001);
    wr(`NVP_OFS_PEND_CLR, 32'h0000_0001);
    rd(`NVP_OFS_PEND_SET, 32'h8000_0000);
    wr(`NVP_OFS_PEND_CLR, 32'hFFFF_FFFF);
    wr(12'h300, 32'hFFFF_FFFF);
    rd(12'h300, 32'h0000_0000);
  endtask : t_regs
  // Disabled line goes pending, ignores entry, raises the masked-pend event
  task automatic t_masked();
    wr(`NVP_OFS_EV_CLR, 32'h0000_0007);
    wr(`NVP_OFS_EV_EN, 32'h0000_0004);
    rd(`NVP_OFS_EV_EN, 32'h0000_0004);
    i_src.pulse(5'd3);
    repeat (5) @(posedge clk);
    i_src.enter(5'd3);
    rd(`NVP_OFS_PEND_SET, 32'h0000_0008);
    rd(`NVP_OFS_ACTIVE, 32'h0000_0000);
    rd(`NVP_OFS_EV_STAT, 32'h0000_0005);
    cmp({31'h0, ctrl_irq}, 32'h0000_0001);
    wr(`NVP_OFS_EV_EN, 32'h0000_0000);
    repeat (3) @(negedge clk);
    cmp({31'h0, ctrl_irq}, 32'h0000_0000);
    wr(`NVP_OFS_EV_EN, 32'h0000_0004);
    wr(`NVP_OFS_EV_CLR, 32'h0000_0007);
    repeat (3) @(negedge clk);
    cmp({31'h0, ctrl_irq}, 32'h0000_0000);
    rd(`NVP_OFS_EV_STAT, 32'h0000_0000);
    wr(`NVP_OFS_PEND_CLR, 32'h0000_0008);
    rd(`NVP_OFS_PEND_SET, 32'h0000_0000);
  endtask : t_masked
  // Pulses while active, disable while active, pending clear while active
  task automatic t_active();
    wr(`NVP_OFS_EN_SET, 32'h0000_0001);
    i_src.pulse(5'd0);
    repeat (5) @(posedge clk);
    cmp(line_request_bits, 32'h0000_0001);
    i_src.enter(5'd0);
    rd(`NVP_OFS_ACTIVE, 32'h0000_0001);
    rd(`NVP_OFS_PEND_SET, 32'h0000_0000);
    i_src.pulse(5'd0);
    i_src.pulse(5'd0);
    repeat (5) @(posedge clk);
    rd(`NVP_OFS_PEND_SET, 32'h0000_0001);
    wr(`NVP_OFS_EN_CLR, 32'h0000_0001);
    rd(`NVP_OFS_ACTIVE, 32'h0000_0001);
    wr(`NVP_OFS_PEND_CLR, 32'h0000_0001);
    rd(`NVP_OFS_PEND_SET, 32'h0000_0000);
    rd(`NVP_OFS_ACTIVE, 32'h0000_0001);
    i_src.leave(5'd0);
    rd(`NVP_OFS_ACTIVE, 32'h0000_0000);
    rd(`NVP_OFS_PEND_SET, 32'h0000_0000);
  endtask : t_active
  // Level held high through return and clear-all; clear refused while high
  task automatic t_level();
    wr(`NVP_OFS_EN_SET, 32'h0000_0020);
    i_src.level(5'd5, 1'b1);
    repeat (5) @(posedge clk);
    i_src.enter(5'd5);
    rd(`NVP_OFS_PEND_SET, 32'h0000_0000);
    i_src.leave(5'd5);
    rd(`NVP_OFS_PEND_SET, 32'h0000_0020);
    wr(`NVP_OFS_PEND_CLR, 32'h0000_0020);
    rd(`NVP_OFS_PEND_SET, 32'h0000_0020);
    i_src.enter(5'd5);
    wr(`NVP_OFS_APP_CTRL, 32'h0000_0002);
    rd(`NVP_OFS_ACTIVE, 32'h0000_0000);
    rd(`NVP_OFS_PEND_SET, 32'h0000_0020);
    i_src.level(5'd5, 1'b0);
    repeat (5) @(posedge clk);
    wr(`NVP_OFS_PEND_CLR, 32'h0000_0020);
    rd(`NVP_OFS_PEND_SET, 32'h0000_0000);
  endtask : t_level
  // Priority bytes, partial lanes and the last word
  task automatic t_prio();
    wr(`NVP_OFS_PRIO0 + 12'h004, 32'h1122_3344);
    rd(`NVP_OFS_PRIO0 + 12'h004, 32'h1122_3344);
    cmp({24'h0, line_priority_bits[39:32]}, 32'h0000_0044);
    wr(`NVP_OFS_PRIO0 + 12'h004, 32'hFFFF_FFFF, 4'b0010);
    rd(`NVP_OFS_PRIO0 + 12'h004, 32'h1122_FF44);
    wr(`NVP_OFS_PRIO7, 32'hA1B2_C3D4);
    @(negedge clk);
    cmp(line_priority_bits[255:224], 32'hA1B2_C3D4);
  endtask : t_prio
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////////
  // Reset for 20 cycles, then the scenarios in turn
  initial begin
    rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = '0;
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_masked();
    t_active();
    t_level();
    t_prio();
    report_and_stop();
  end
endmodule : nvp_ctrl_tb_top

// [nvp_line.sv]
/*
 * One interrupt line: pending, enable and active state.
 * Assumes its inputs are already synchronised to clk and that the
 * write strobes are one-cycle pulses from the register slave.
 */
`timescale 1ns/1ns
module nvp_line #(
  parameter bit PRESENT   = 1'b1,
  parameter bit ALWAYS_EN = 1'b0,
  parameter bit PULSE     = 1'b1,
  parameter bit SW_SET    = 1'b1,
  parameter bit SW_CLR    = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic irq_level,
  input  wire logic irq_rise,
  input  wire logic sample_hi,
  input  wire logic entry,
  input  wire logic ret,
  input  wire logic clr_all,
  input  wire logic set_en,
  input  wire logic clr_en,
  input  wire logic set_pend,
  input  wire logic clr_pend,
  output logic      pending,
  output logic      enabled,
  output logic      active,
  output logic      ev_pend,
  output logic      ev_repend,
  output logic      ev_masked
);
  logic pending_ff;
  logic enabled_ff;
  logic active_ff;
  logic assert_ev;
  logic entry_ok;
  logic set_c;
  logic clr_c;

  //////////////////////////////////////////////////////////////////////
  // Assertion and clear terms
  // rise or sampled high
  // level lines also re-pend while idle
  assign assert_ev = irq_rise | (irq_level & sample_hi) | (!PULSE & irq_level & !active_ff & !entry);
  assign entry_ok  = entry & enabled_ff;
  assign set_c     = PRESENT & (assert_ev | (SW_SET & set_pend));
  // entry while enabled, or software clear with input low
  assign clr_c     = entry_ok | (SW_CLR & clr_pend & !irq_level);

  // Pending bit; set beats clear so no event is lost
  // new pulse sets pending while active
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_ff <= 1'b0;
    end else begin
      pending_ff <= set_c | (pending_ff & !clr_c);
    end
  end

  // Enable bit
  // absent lines tie low, fixed lines tie high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enabled_ff <= ALWAYS_EN & PRESENT;
    end else if (!PRESENT) begin
      enabled_ff <= 1'b0;
    end else if (ALWAYS_EN) begin
      enabled_ff <= 1'b1;
    end else if (set_en) begin
      enabled_ff <= 1'b1;
    end else if (clr_en) begin
      enabled_ff <= 1'b0;
    end
  end

  // Active state, untouched by enable and pending writes
  // only return, clear-all-active or reset ends it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_ff <= 1'b0;
    end else if (entry_ok) begin
      active_ff <= 1'b1;
    end else if (ret | clr_all) begin
      active_ff <= 1'b0;
    end
  end

  assign pending   = pending_ff;
  assign enabled   = enabled_ff;
  assign active    = active_ff;
  assign ev_pend   = set_c & !pending_ff;
  assign ev_repend = PRESENT & irq_level & ret;
  assign ev_masked = set_c & !enabled_ff;
endmodule : nvp_line

// [nvp_pkg.sv]
/*
 * Types shared by the interrupt line pending and enable logic.
 * Assumes nothing of its surroundings.
 */
package nvp_pkg;
  typedef logic [31:0] nvp_word_t;
  typedef logic [11:0] nvp_addr_t;
  typedef logic [3:0]  nvp_be_t;
  typedef logic [4:0]  nvp_idx_t;
endpackage : nvp_pkg

// [nvp_regs.svh]
/*
 * Register offsets, field positions, reset values and counts of the
 * interrupt line pending and enable logic.
 * Assumes byte addresses relative to the block's own base on the bus.
 */
`ifndef NVP_REGS_SVH
`define NVP_REGS_SVH

// Line count and priority packing
`define NVP_LINES         32
`define NVP_PRIO_W        8
`define NVP_PRIO_REGS     8

// Byte offsets of the line registers
`define NVP_OFS_EN_SET    12'h100
`define NVP_OFS_EN_CLR    12'h180
`define NVP_OFS_PEND_SET  12'h200
`define NVP_OFS_PEND_CLR  12'h280
`define NVP_OFS_PRIO0     12'h400
`define NVP_OFS_PRIO7     12'h41C

// Byte offsets of the control and event registers
`define NVP_OFS_APP_CTRL  12'h600
`define NVP_OFS_ACTIVE    12'h640
`define NVP_OFS_EV_STAT   12'h680
`define NVP_OFS_EV_CLR    12'h684
`define NVP_OFS_EV_EN     12'h688

// Field positions
`define NVP_CLRACT_BIT    1
`define NVP_EV_PEND       0
`define NVP_EV_REPEND     1
`define NVP_EV_MASKED     2
`define NVP_EV_BITS       3

// Reset values
`define NVP_RST_WORD      32'h0000_0000
`define NVP_RST_EV        3'h0

`endif

// [nvp_src_model.sv]
/* Model of the peripheral sources and the exception logic around nvp_ctrl.
 * Assumes the bench calls its tasks one at a time; all drives land on clk rises. */
`timescale 1ns/1ns
module nvp_src_model
  import nvp_pkg::*;
(
  input wire logic          clk,
  output logic [31:0]       irq_lines,
  output logic              exception_entry_event,
  output nvp_pkg::nvp_idx_t entry_line_index,
  output logic              exception_return_event,
  output nvp_pkg::nvp_idx_t return_line_index
);
  // Quiet lines and no exception traffic at start
  initial begin
    irq_lines = '0;
    exception_entry_event = 1'b0;
    entry_line_index = '0;
    exception_return_event = 1'b0;
    return_line_index = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // pulse held two clocks
  // Long enough for the sync stages, and gone from irq_lines by the time the task returns
  task automatic pulse(input nvp_idx_t n);
    @(posedge clk);
    irq_lines[n] <= 1'b1;
    repeat (2) @(posedge clk);
    irq_lines[n] <= 1'b0;
  endtask : pulse
  // Level source held until told otherwise
  task automatic level(input nvp_idx_t n, input logic v);
    @(posedge clk);
    irq_lines[n] <= v;
  endtask : level
  // One-cycle exception entry strobe
  task automatic enter(input nvp_idx_t n);
    @(posedge clk);
    exception_entry_event <= 1'b1;
    entry_line_index <= n;
    @(posedge clk);
    exception_entry_event <= 1'b0;
  endtask : enter
  // One-cycle exception return strobe
  task automatic leave(input nvp_idx_t n);
    @(posedge clk);
    exception_return_event <= 1'b1;
    return_line_index <= n;
    @(posedge clk);
    exception_return_event <= 1'b0;
  endtask : leave
endmodule : nvp_src_model
